// ==== hw/dcs_clock_ctrl.sv ====
// Sample-clock source select and oscillator band control
// Notes on behaviour
// - Multiplier off: power down, use direct clock
// - Multiplier on: sample clock from multiplied path
// - Oscillator = ref*ratios; sample = oscillator/divide
// - Sixty-three overlapping bands, chosen per part
// - Write 0x80 launches automatic band search
// - Manual enable takes band from field
// - Control-voltage code readable in status low bits
// - Codes: 0111 higher, 1110 lower, 0/1 good
// - Enables for duty and level correction
`timescale 1ns/100ps
`default_nettype none
module dcs_clock_ctrl
    import dcs_pkg::*;
#(
    parameter int SETTLE_CYC = DCS_SETTLE_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire dcs_pkg::dcs_req_t req,
    input wire logic [3:0] cv_code_in,
    input wire logic pll_lock_in,
    output logic [7:0] rdata,
    output logic mult_pd,
    output logic sel_multiplied,
    output logic [5:0] band_out,
    output logic search_busy,
    output logic [1:0] loop_bw,
    output logic [4:0] pump_cur,
    output logic cross_en,
    output logic duty_corr_en,
    output logic level_corr_en
);
    import dcs_pkg::*;

    initial begin
        if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin
            $error("SETTLE_CYC out of range");
        end
    end

    // Two-stage synchronisers for analog status
    logic [3:0] cv_s1_r, cv_s2_r;
    logic lock_s1_r, lock_s2_r;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cv_s1_r <= 4'h0;
            cv_s2_r <= 4'h0;
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
        end else begin
            cv_s1_r <= cv_code_in;
            cv_s2_r <= cv_s1_r;
            lock_s1_r <= pll_lock_in;
            lock_s2_r <= lock_s1_r;
        end
    end

    logic [7:0] mult_r, mult_nxt, loop_r, loop_nxt, cross_r, cross_nxt;
    logic [7:0] corr_r, corr_nxt, rdata_nxt;
    logic [5:0] auto_band_r, auto_band_nxt, band_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    dcs_state_t st_r, st_nxt;
    logic wr_mult;

    assign wr_mult = req.we && req.addr == DCS_OFS_MULT_CTRL;

    // Register file, search engine and derived outputs
    always_comb begin
        mult_nxt = mult_r;
        loop_nxt = loop_r;
        cross_nxt = cross_r;
        corr_nxt = corr_r;
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        auto_band_nxt = auto_band_r;
        if (req.we) begin
            case (req.addr)
                DCS_OFS_MULT_CTRL: mult_nxt = req.wdata;
                DCS_OFS_LOOP_TUNE: loop_nxt = req.wdata;
                DCS_OFS_CROSS_CTRL: cross_nxt = req.wdata;
                DCS_OFS_CLK_CORR: corr_nxt = req.wdata;
                default: ;
            endcase
        end
        case (st_r)
            DCS_IDLE: begin
                if (wr_mult && req.wdata == DCS_CMD_AUTO) begin
                    st_nxt = DCS_WAIT;
                    auto_band_nxt = 6'h00;
                    cnt_nxt = 16'h0000;
                end
            end
            DCS_WAIT: begin
                // Each band gets time for the loop to settle
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == 16'(SETTLE_CYC - 1)) begin
                    st_nxt = DCS_JUDGE;
                end
            end
            DCS_JUDGE: begin
                // Accept optimal code, else step upward
                // Walk the band range, per part
                if (lock_s2_r && (cv_s2_r == DCS_CV_MID0 ||
                        cv_s2_r == DCS_CV_MID1)) begin
                    st_nxt = DCS_IDLE;
                end else if (auto_band_r == DCS_BAND_LAST) begin
                    st_nxt = DCS_IDLE; // No fit: keep last band
                end else begin
                    auto_band_nxt = auto_band_r + 6'h01;
                    cnt_nxt = 16'h0000;
                    st_nxt = DCS_WAIT;
                end
            end
            default: st_nxt = DCS_IDLE;
        endcase
        // Leaving the search early if multiplier gets switched off
        if (!mult_nxt[DCS_BIT_MULT_EN]) begin
            st_nxt = DCS_IDLE;
        end
        // Manual band field wins when enabled
        band_nxt = mult_nxt[DCS_BIT_MAN_EN] ? mult_nxt[5:0] : auto_band_nxt;
        case (req.addr)
            DCS_OFS_MULT_CTRL: rdata_nxt = mult_nxt;
            DCS_OFS_LOOP_TUNE: rdata_nxt = loop_nxt;
            DCS_OFS_CROSS_CTRL: rdata_nxt = cross_nxt;
            DCS_OFS_CLK_CORR: rdata_nxt = corr_nxt;
            DCS_OFS_TUNE_STAT: rdata_nxt = {4'h0, cv_s2_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mult_r <= DCS_RST_MULT_CTRL;
            loop_r <= DCS_RST_LOOP_TUNE;
            cross_r <= DCS_RST_CROSS_CTRL;
            corr_r <= DCS_RST_CLK_CORR;
            st_r <= DCS_IDLE;
            cnt_r <= 16'h0000;
            auto_band_r <= 6'h00;
            rdata <= 8'h00;
            band_out <= 6'h00;
            mult_pd <= 1'b1;
            sel_multiplied <= 1'b0;
            search_busy <= 1'b0;
            loop_bw <= 2'h0;
            pump_cur <= 5'h00;
            cross_en <= 1'b0;
            duty_corr_en <= 1'b0;
            level_corr_en <= 1'b0;
        end else begin
            mult_r <= mult_nxt;
            loop_r <= loop_nxt;
            cross_r <= cross_nxt;
            corr_r <= corr_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            auto_band_r <= auto_band_nxt;
            rdata <= rdata_nxt;
            band_out <= band_nxt;
            // Power down and direct source when off
            mult_pd <= !mult_nxt[DCS_BIT_MULT_EN];
            // Ratios applied in the analog loop
            sel_multiplied <= mult_nxt[DCS_BIT_MULT_EN];
            search_busy <= st_nxt != DCS_IDLE;
            loop_bw <= loop_nxt[7:6];
            pump_cur <= loop_nxt[4:0];
            cross_en <= cross_nxt[DCS_BIT_CROSS_EN];
            duty_corr_en <= corr_nxt[DCS_BIT_DUTY_EN];
            level_corr_en <= corr_nxt[DCS_BIT_LEVEL_EN];
        end
    end
endmodule
`default_nettype wire

// ==== hw/dcs_pkg.sv ====
// Package for the sample-clock source and oscillator band control block
package dcs_pkg;
    // Register offsets on the configuration port
    localparam logic [7:0] DCS_OFS_CLK_CORR = 8'h08;
    localparam logic [7:0] DCS_OFS_MULT_CTRL = 8'h0A;
    localparam logic [7:0] DCS_OFS_LOOP_TUNE = 8'h0C;
    localparam logic [7:0] DCS_OFS_CROSS_CTRL = 8'h0D;
    localparam logic [7:0] DCS_OFS_TUNE_STAT = 8'h0E;
    // Field positions
    localparam int DCS_BIT_MULT_EN = 7;
    localparam int DCS_BIT_MAN_EN = 6;
    localparam int DCS_BIT_DUTY_EN = 0;
    localparam int DCS_BIT_LEVEL_EN = 1;
    localparam int DCS_BIT_CROSS_EN = 4;
    // Reset values
    localparam logic [7:0] DCS_RST_MULT_CTRL = 8'h00;
    localparam logic [7:0] DCS_RST_LOOP_TUNE = 8'h00;
    localparam logic [7:0] DCS_RST_CROSS_CTRL = 8'h00;
    localparam logic [7:0] DCS_RST_CLK_CORR = 8'h00;
    // Automatic search launch value and band limits
    localparam logic [7:0] DCS_CMD_AUTO = 8'h80;
    localparam logic [5:0] DCS_BAND_LAST = 6'h3E;
    // Control-voltage codes
    localparam logic [3:0] DCS_CV_HIGHER = 4'h7;
    localparam logic [3:0] DCS_CV_LOWER = 4'hE;
    localparam logic [3:0] DCS_CV_MID0 = 4'h0;
    localparam logic [3:0] DCS_CV_MID1 = 4'h1;
    // Settle wait per band step during search
    localparam int DCS_SETTLE_NS = 1000;
    localparam int DCS_CLK_NS = 10;
    localparam int DCS_SETTLE_CYC = DCS_SETTLE_NS / DCS_CLK_NS;

    // Register write request
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dcs_req_t;

    // Search states
    typedef enum logic [2:0] {
        DCS_IDLE = 3'b001,
        DCS_WAIT = 3'b010,
        DCS_JUDGE = 3'b100
    } dcs_state_t;
endpackage

// ==== testbench/dcs_clock_ctrl_asserts.sv ====
// Port checks for the clock control block
`timescale 1ns/100ps
`default_nettype none
module dcs_chk
    import dcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire dcs_pkg::dcs_req_t req,
    input wire logic [7:0] rdata,
    input wire logic mult_pd,
    input wire logic sel_multiplied,
    input wire logic [5:0] band_out,
    input wire logic search_busy,
    input wire logic [1:0] loop_bw,
    input wire logic [4:0] pump_cur,
    input wire logic duty_corr_en,
    input wire logic level_corr_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic wm;
    // Write to the multiplier control register
    assign wm = req.we && req.addr == DCS_OFS_MULT_CTRL;
    AST_PD: assert property (mult_pd != sel_multiplied)
        else $error("power-down and path select disagree");
    AST_SEL: assert property (wm |=> sel_multiplied == $past(req.wdata[7]))
        else $error("path select not from enable bit");
    AST_MAN: assert property (wm && req.wdata[7:6] == 2'b11 && !search_busy
        |=> band_out == $past(req.wdata[5:0]))
        else $error("manual band not applied");
    AST_AUTO: assert property (wm && req.wdata == DCS_CMD_AUTO && !search_busy
        |=> search_busy && band_out == 6'h00)
        else $error("search did not start");
    AST_BAND: assert property (band_out <= DCS_BAND_LAST)
        else $error("band above last");
    AST_STAT: assert property (req.addr == DCS_OFS_TUNE_STAT |=>
        rdata[7:4] == 4'h0)
        else $error("status high bits set");
    AST_LOOP: assert property (req.we && req.addr == DCS_OFS_LOOP_TUNE |=>
        {loop_bw, pump_cur} == {$past(req.wdata[7:6]), $past(req.wdata[4:0])})
        else $error("loop fields wrong");
    AST_CORR: assert property (req.we && req.addr == DCS_OFS_CLK_CORR |=>
        {level_corr_en, duty_corr_en} == $past(req.wdata[1:0]))
        else $error("correction enables wrong");
endmodule
bind dcs_clock_ctrl dcs_chk u_dcs_chk (.clk_sys, .arst_n, .req, .rdata,
    .mult_pd, .sel_multiplied, .band_out, .search_busy, .loop_bw, .pump_cur,
    .duty_corr_en, .level_corr_en);
`default_nettype wire

// ==== testbench/dcs_pll_model.sv ====
// Behavioural oscillator loop seen from the band select
`timescale 1ns/100ps
`default_nettype none
module dcs_pll_model #(
    parameter logic [5:0] TGT = 6'h05
) (
    input wire logic sel_multiplied,
    input wire logic [5:0] band_out,
    output logic [3:0] cv_code_in,
    output logic pll_lock_in
);
    // target band stands for an in-range oscillator setting
    always_comb begin
        pll_lock_in = sel_multiplied && band_out >= TGT;
        if (band_out < TGT) cv_code_in = 4'h7;
        else if (band_out == TGT) cv_code_in = 4'h0;
        else cv_code_in = 4'hE;
    end
endmodule
`default_nettype wire

// ==== testbench/dcs_clock_ctrl_tb_top.sv ====
// Register-level tests of the clock control block
`timescale 1ns/100ps
`default_nettype none
module dcs_clock_ctrl_tb_top;
    import dcs_pkg::*;
    logic clk_sys, arst_n, mult_pd, sel_multiplied, search_busy, cross_en;
    logic duty_corr_en, level_corr_en, pll_lock_in;
    logic [7:0] rdata;
    logic [5:0] band_out;
    logic [3:0] cv_code_in;
    logic [1:0] loop_bw;
    logic [4:0] pump_cur;
    dcs_req_t req;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    dcs_clock_ctrl #(.SETTLE_CYC(4)) u_dcs_clock_ctrl (.clk_sys, .arst_n,
        .req, .cv_code_in, .pll_lock_in, .rdata, .mult_pd, .sel_multiplied,
        .band_out, .search_busy, .loop_bw, .pump_cur, .cross_en,
        .duty_corr_en, .level_corr_en);
    dcs_pll_model u_dcs_pll_model (.sel_multiplied, .band_out, .cv_code_in,
        .pll_lock_in);
    initial begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{1'b1, a, d};
        @(posedge clk_sys);
        req.we <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        req.addr <= a;
        @(posedge clk_sys);
        #1 chk(rdata, e);
    endtask
    // Manual band then status after sync delay
    task automatic sweep(input logic [5:0] b, input logic [7:0] e);
        wr(DCS_OFS_MULT_CTRL, {2'b11, b});
        repeat (3) @(posedge clk_sys);
        rd(DCS_OFS_TUNE_STAT, e);
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        arst_n = 0;
        req = '0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1;
        chk(8'(mult_pd), 8'h01);
        rd(DCS_OFS_MULT_CTRL, DCS_RST_MULT_CTRL);
        rd(DCS_OFS_LOOP_TUNE, DCS_RST_LOOP_TUNE);
        $display("reset test done");
        wr(DCS_OFS_LOOP_TUNE, 8'hC1);
        wr(DCS_OFS_CROSS_CTRL, 8'h10);
        chk({loop_bw, 1'b0, pump_cur}, 8'hC1);
        chk(8'(cross_en), 8'h01);
        wr(DCS_OFS_CLK_CORR, 8'h03);
        chk({6'h00, level_corr_en, duty_corr_en}, 8'h03);
        wr(DCS_OFS_TUNE_STAT, 8'hFF);
        wr(8'h3F, 8'h55);
        rd(8'h3F, 8'h00);
        $display("config test done");
        wr(DCS_OFS_MULT_CTRL, 8'hC9);
        chk({mult_pd, sel_multiplied, band_out}, 8'h49);
        sweep(6'h09, 8'h0E);
        sweep(6'h03, 8'h07);
        sweep(6'h05, 8'h00);
        $display("manual test done");
        wr(DCS_OFS_MULT_CTRL, 8'h00);
        chk({mult_pd, sel_multiplied, 6'h00}, 8'h80);
        wr(DCS_OFS_MULT_CTRL, DCS_CMD_AUTO);
        chk(8'(search_busy), 8'h01);
        for (int i = 0; i < 300 && search_busy; i++) @(negedge clk_sys);
        chk({search_busy, sel_multiplied, band_out}, 8'h45);
        $display("auto test done");
        final_report();
    end
endmodule
`default_nettype wire
